/* src/spfc_pkg.sv */
package spfc_pkg;

  // ****************************************************************
  // Register map and control field layout
  // ****************************************************************
  localparam logic [11:0] CSR_ADDR    = 12'h000;
  localparam logic [11:0] STATUS_ADDR = 12'h004;

  localparam int SPMEN_BIT = 0;
  localparam int PAGE_ERASE_BIT_BIT = 1;
  localparam int PAGE_WRITE_BIT_BIT = 2;
  localparam int READ_FUSE_BIT_BIT  = 3;
  localparam int CLEAR_BUFFER_BIT_BIT  = 4;
  localparam int CMD_BITS  = 5;

  localparam logic [4:0] CSR_RESET = 5'h00;
  localparam logic [4:0] CMD_CLEAR = 5'h11;
  localparam logic [4:0] CMD_FUSE  = 5'h09;
  localparam logic [4:0] CMD_WRITE = 5'h05;
  localparam logic [4:0] CMD_ERASE = 5'h03;
  localparam logic [4:0] CMD_STORE = 5'h01;

  localparam int STAT_BUSY_BIT   = 0;
  localparam int STAT_FUSEEN_BIT = 1;
  localparam int STAT_MASK_LSB   = 16;

  // ****************************************************************
  // Arming windows in clock cycles
  // ****************************************************************
  localparam logic [2:0] SPM_WINDOW = 3'h4;
  localparam logic [2:0] LPM_WINDOW = 3'h3;

  // ****************************************************************
  // Fuse and lock selection by low pointer bits
  // ****************************************************************
  localparam logic [1:0] SEL_LOW_FUSE  = 2'h0;
  localparam logic [1:0] SEL_LOCK      = 2'h1;
  localparam logic [1:0] SEL_EXT_FUSE  = 2'h2;
  localparam logic [1:0] SEL_HIGH_FUSE = 2'h3;

  localparam logic [15:0] ERASED_WORD = 16'hFFFF;

  // ****************************************************************
  // Timing: pclk 40 MHz, programming oscillator 8 MHz
  // ****************************************************************
  localparam longint CLK_PERIOD_PS    = 25000;
  localparam int     OSC_DIV          = 5;
  localparam longint OSC_PERIOD_PS    = CLK_PERIOD_PS * OSC_DIV;
  localparam longint PROG_MIN_TIME_NS = 3700000;
  localparam longint PROG_MAX_TIME_NS = 4500000;
  localparam longint PROG_MIN_TICKS =
    (PROG_MIN_TIME_NS * 1000 + OSC_PERIOD_PS - 1) / OSC_PERIOD_PS;
  localparam longint PROG_MAX_TICKS =
    (PROG_MAX_TIME_NS * 1000) / OSC_PERIOD_PS;
  localparam int unsigned PROG_TICKS = 32'(PROG_MIN_TICKS);

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    ENG_IDLE  = 3'b001,
    ENG_ERASE = 3'b010,
    ENG_WRITE = 3'b100
  } spfc_eng_t;

  typedef struct packed {
    logic        store_program_instruction;
    logic        load_program_instruction;
    logic [15:0] pointer;
    logic [15:0] data_register_pair;
  } spfc_core_req_t;

  typedef struct packed {
    logic [7:0] low_fuse_byte;
    logic [7:0] high_fuse_byte;
    logic [7:0] ext_fuse_byte;
    logic [7:0] lock_byte;
  } spfc_fuse_t;

endpackage

/* src/spfc_top.sv */
`timescale 1ns/1ps
// Contract
// (R1) Pointer low bits pick word in page, high bits pick page.
// (R2) Load-program addresses bytes; pointer bit zero picks low or high byte.
// (R3) Control bits 7..5 read as zero.
// (R4) Clear-buffer command discards the whole temporary page buffer.
// (R5) Armed read-fuse load returns lock or fuse byte within three cycles.
// (R6) Armed page write with store within four cycles writes buffer to page.
// (R7) Page-write bit clears on finish or timeout; core halted meanwhile.
// (R8) Armed page erase with store within four cycles erases pointer page.
// (R9) Page-erase bit clears on finish or timeout; core halted meanwhile.
// (R10) Enable bit allows store-program only four cycles after the write.
// (R11) Plain enable store puts data pair in buffer word, pointer bit 0 ignored.
// (R12) Enable clears after store or timeout, held during erase or write.
// (R13) Only five command patterns act; any other write does nothing.
// (R14) EEPROM write blocks programming and fuse or lock reads.
// (R15) Software should check EEPROM busy before writing control.
// (R16) Lock byte read via pointer one with read-fuse armed.
// (R17) Read-fuse and enable clear on read, three or four cycle timeout.
// (R18) Armed fuse read at pointer zero returns low fuse byte.
// (R19) Armed fuse read at pointer three returns high fuse byte.
// (R20) Programmed bits read zero, unprogrammed read one.
// (R21) Flash write in progress completes despite a system reset; presetn clears buf_filled, so a reset page write programs no word.
// (R22) Erase and write timed from oscillator between minimum and maximum.
// (R23) Store-program disabled unless self-program fuse is zero.
// (R24) Buffer erased after each page write and after system reset.
// (R25) EEPROM write during page loading loses buffered data.
// (R26) Core gives single-cycle strobes with pointer and data valid.
module spfc_top #(
  parameter int          PAGE_WORDS  = 16,
  parameter int          FLASH_WORDS = 1024,
  parameter int          OSC_DIV     = spfc_pkg::OSC_DIV,
  parameter int unsigned PROG_TICKS  = spfc_pkg::PROG_TICKS
) (
  // Clock and resets
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     por_n,
  // APB slave
  input  wire logic [11:0]              paddr,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  // Core instruction strobes
  input  wire spfc_pkg::spfc_core_req_t core_req,
  output logic      [7:0]               lpm_data,
  output logic                          lpm_valid,
  output logic                          core_halt,
  // EEPROM status
  input  wire logic                     eeprom_write_busy,
  input  wire logic                     eeprom_write_start,
  // Fuse and lock bytes
  input  wire spfc_pkg::spfc_fuse_t     fuses
);

  localparam int WORD_BITS = $clog2(PAGE_WORDS);
  localparam int ADDR_BITS = $clog2(FLASH_WORDS);
  localparam int PAGE_BITS = ADDR_BITS - WORD_BITS;

  // ****************************************************************
  // Pointer decoding
  // ****************************************************************
  function automatic logic [WORD_BITS-1:0] word_of(input logic [15:0] p);
    return p[WORD_BITS:1]; // [R1] [R11]
  endfunction

  function automatic logic [PAGE_BITS-1:0] page_of(input logic [15:0] p);
    return p[ADDR_BITS:WORD_BITS+1]; // [R1]
  endfunction

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [15:0]           flash_mem [FLASH_WORDS];
  logic [15:0]           page_buf  [PAGE_WORDS];
  logic [PAGE_WORDS-1:0] buf_filled;

  // ****************************************************************
  // Control state
  // ****************************************************************
  logic [4:0]              csr;
  logic [2:0]              spm_cnt;
  logic [2:0]              lpm_cnt;
  spfc_pkg::spfc_eng_t     eng_state;
  logic [PAGE_BITS-1:0]    eng_page;
  logic [31:0]             eng_ticks;
  logic [7:0]              osc_cnt;
  logic                    osc_tick;
  logic                    eng_busy;
  logic                    eng_finish;
  logic                    fuse_spm_en;
  logic                    apb_setup;
  logic                    csr_wr;
  logic [4:0]              cmd;
  logic                    cmd_valid;
  logic                    cmd_ok;
  logic                    spm_ok;
  logic                    fuse_hit;
  logic                    start_erase;
  logic                    start_write;
  logic                    store_word;
  logic                    buf_clear;
  logic [7:0]              fuse_sel;
  logic [15:0]             flash_word;
  logic [31:0]             status_word;

  // ****************************************************************
  // Command decode
  // ****************************************************************
  assign fuse_spm_en = ~fuses.ext_fuse_byte[0]; // [R23]
  assign apb_setup   = psel & ~penable;
  assign csr_wr      = psel & penable & pready & pwrite
                       & (paddr == spfc_pkg::CSR_ADDR);
  assign cmd         = pwdata[spfc_pkg::CMD_BITS-1:0];
  assign cmd_valid   = (cmd == spfc_pkg::CMD_CLEAR)
                     | (cmd == spfc_pkg::CMD_FUSE)
                     | (cmd == spfc_pkg::CMD_WRITE)
                     | (cmd == spfc_pkg::CMD_ERASE)
                     | (cmd == spfc_pkg::CMD_STORE); // [R13]
  assign eng_busy    = (eng_state != spfc_pkg::ENG_IDLE);
  assign cmd_ok      = csr_wr & cmd_valid & ~eeprom_write_busy
                       & ~eng_busy; // [R13] [R14]

  assign spm_ok = core_req.store_program_instruction
                  & (spm_cnt != 3'h0) & fuse_spm_en
                  & ~eeprom_write_busy & ~eng_busy; // [R10] [R14] [R23]
  assign fuse_hit = core_req.load_program_instruction
                    & csr[spfc_pkg::READ_FUSE_BIT_BIT] & (lpm_cnt != 3'h0)
                    & ~eeprom_write_busy; // [R5] [R14] [R16]

  assign start_erase = spm_ok & (csr == spfc_pkg::CMD_ERASE); // [R8]
  assign start_write = spm_ok & (csr == spfc_pkg::CMD_WRITE); // [R6]
  assign store_word  = spm_ok & (csr == spfc_pkg::CMD_STORE); // [R11]

  // Buffer lost on clear command, page write end or EEPROM write
  assign buf_clear = (cmd_ok & (cmd == spfc_pkg::CMD_CLEAR))        // [R4]
                   | (eng_finish & (eng_state == spfc_pkg::ENG_WRITE)) // [R24]
                   | eeprom_write_start;                            // [R25]

  // ****************************************************************
  // Control and status register with arming windows
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      csr     <= spfc_pkg::CSR_RESET;
      spm_cnt <= 3'h0;
      lpm_cnt <= 3'h0;
    end else if (cmd_ok) begin
      csr     <= cmd;
      spm_cnt <= spfc_pkg::SPM_WINDOW; // [R10]
      lpm_cnt <= (cmd == spfc_pkg::CMD_FUSE) ? spfc_pkg::LPM_WINDOW
                                             : 3'h0; // [R5]
    end else begin
      if (spm_cnt != 3'h0) begin
        spm_cnt <= spm_cnt - 3'h1;
      end
      if (lpm_cnt != 3'h0) begin
        lpm_cnt <= lpm_cnt - 3'h1;
      end
      if (eng_finish) begin
        csr <= spfc_pkg::CSR_RESET; // [R7] [R9] [R12]
      end else if (start_erase | start_write) begin
        spm_cnt <= 3'h0; // [R12]
      end else if (spm_ok | fuse_hit) begin
        csr     <= spfc_pkg::CSR_RESET; // [R12] [R17]
        spm_cnt <= 3'h0;
        lpm_cnt <= 3'h0;
      end else if (!eng_busy && spm_cnt == 3'h1) begin
        csr <= spfc_pkg::CSR_RESET; // [R7] [R9] [R12] [R17]
      end else if (csr[spfc_pkg::READ_FUSE_BIT_BIT] && lpm_cnt == 3'h1) begin
        csr     <= spfc_pkg::CSR_RESET; // [R17]
        spm_cnt <= 3'h0;
      end
    end
  end

  // ****************************************************************
  // Temporary page buffer
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_filled <= '0; // [R24]
    end else if (buf_clear) begin
      buf_filled <= '0; // [R4] [R24] [R25]
    end else if (store_word) begin
      buf_filled[word_of(core_req.pointer)] <= 1'b1;
    end
  end

  // Second load of a word without clearing ANDs like flash cells
  always_ff @(posedge pclk) begin
    if (store_word) begin
      if (buf_filled[word_of(core_req.pointer)]) begin
        page_buf[word_of(core_req.pointer)] <=
          page_buf[word_of(core_req.pointer)]
          & core_req.data_register_pair;
      end else begin
        page_buf[word_of(core_req.pointer)] <=
          core_req.data_register_pair; // [R11]
      end
    end
  end

  // ****************************************************************
  // Programming oscillator enable
  // ****************************************************************
  assign osc_tick = (osc_cnt == 8'(OSC_DIV - 1));

  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      osc_cnt <= 8'h00;
    end else if (osc_tick) begin
      osc_cnt <= 8'h00;
    end else begin
      osc_cnt <= osc_cnt + 8'h01;
    end
  end

  // ****************************************************************
  // Erase and write engine, kept alive through system reset
  // ****************************************************************
  assign eng_finish = eng_busy & osc_tick
                      & (eng_ticks == PROG_TICKS - 32'd1); // [R22]

  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      eng_state <= spfc_pkg::ENG_IDLE;
      eng_page  <= '0;
      eng_ticks <= 32'h0000_0000;
      core_halt <= 1'b0;
    end else begin
      case (eng_state)
        spfc_pkg::ENG_IDLE: begin
          eng_ticks <= 32'h0000_0000;
          if (presetn && (start_erase || start_write)) begin
            eng_state <= start_write ? spfc_pkg::ENG_WRITE
                                     : spfc_pkg::ENG_ERASE; // [R6] [R8]
            eng_page  <= page_of(core_req.pointer); // [R1]
            core_halt <= 1'b1; // [R7] [R9]
          end
        end
        spfc_pkg::ENG_ERASE,
        spfc_pkg::ENG_WRITE: begin
          if (eng_finish) begin
            eng_state <= spfc_pkg::ENG_IDLE;
            core_halt <= 1'b0; // [R7] [R9]
          end else if (osc_tick) begin
            eng_ticks <= eng_ticks + 32'd1; // [R21] [R22]
          end
        end
        default: begin
          eng_state <= spfc_pkg::ENG_IDLE;
          core_halt <= 1'b0;
        end
      endcase
    end
  end

  // Flash array update at the end of the programming time
  always_ff @(posedge pclk) begin
    if (eng_finish) begin
      for (int w = 0; w < PAGE_WORDS; w++) begin
        if (eng_state == spfc_pkg::ENG_ERASE) begin
          flash_mem[{eng_page, WORD_BITS'(w)}] <=
            spfc_pkg::ERASED_WORD; // [R8]
        end else if (buf_filled[w]) begin
          flash_mem[{eng_page, WORD_BITS'(w)}] <=
            flash_mem[{eng_page, WORD_BITS'(w)}] & page_buf[w]; // [R6]
        end
      end
    end
  end

  // ****************************************************************
  // Load-program answers
  // ****************************************************************
  always_comb begin
    case (core_req.pointer[1:0])
      spfc_pkg::SEL_LOW_FUSE:  fuse_sel = fuses.low_fuse_byte;  // [R18]
      spfc_pkg::SEL_LOCK:      fuse_sel = fuses.lock_byte;      // [R16]
      spfc_pkg::SEL_EXT_FUSE:  fuse_sel = fuses.ext_fuse_byte;
      spfc_pkg::SEL_HIGH_FUSE: fuse_sel = fuses.high_fuse_byte; // [R19]
      default:                 fuse_sel = fuses.low_fuse_byte;
    endcase
  end

  assign flash_word = flash_mem[core_req.pointer[ADDR_BITS:1]];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lpm_data  <= 8'h00;
      lpm_valid <= 1'b0;
    end else begin
      lpm_valid <= core_req.load_program_instruction;
      if (fuse_hit) begin
        lpm_data <= fuse_sel; // [R5] [R20]
      end else if (core_req.load_program_instruction) begin
        lpm_data <= core_req.pointer[0] ? flash_word[15:8]
                                        : flash_word[7:0]; // [R2] [R17]
      end
    end
  end

  // ****************************************************************
  // APB slave: one wait-free access phase, error on unmapped address
  // ****************************************************************
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[spfc_pkg::STAT_BUSY_BIT]   = eng_busy;
    status_word[spfc_pkg::STAT_FUSEEN_BIT] = fuse_spm_en;
    status_word[spfc_pkg::STAT_MASK_LSB +: PAGE_WORDS] = buf_filled;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= apb_setup;
      pslverr <= apb_setup & (paddr != spfc_pkg::CSR_ADDR)
                 & (paddr != spfc_pkg::STATUS_ADDR);
      prdata  <= 32'h0000_0000;
      if (apb_setup && !pwrite) begin
        if (paddr == spfc_pkg::CSR_ADDR) begin
          prdata <= {27'h0, csr}; // [R3]
        end else if (paddr == spfc_pkg::STATUS_ADDR) begin
          prdata <= status_word;
        end
      end
    end
  end

endmodule // spfc_top

/* bench/spfc_monitor.sv */
`timescale 1ns/1ps
module spfc_monitor #(
  parameter int          OSC_DIV    = 5,
  parameter int unsigned PROG_TICKS = 4
) (
  // Clock and reset
  input wire logic                     pclk,
  input wire logic                     presetn,
  // APB
  input wire logic [11:0]              paddr,
  input wire logic                     psel,
  input wire logic                     penable,
  input wire logic                     pwrite,
  input wire logic [31:0]              pwdata,
  input wire logic [31:0]              prdata,
  input wire logic                     pready,
  input wire logic                     pslverr,
  // Core side
  input wire spfc_pkg::spfc_core_req_t core_req,
  input wire logic [7:0]               lpm_data,
  input wire logic                     lpm_valid,
  input wire logic                     core_halt,
  input wire logic                     eeprom_write_busy,
  input wire spfc_pkg::spfc_fuse_t     fuses
);
  localparam int LO = int'(PROG_TICKS - 1) * OSC_DIV;
  localparam int HI = int'(PROG_TICKS + 1) * OSC_DIV + 2;
  logic [2:0]  spm_cnt, lpm_cnt;
  logic [15:0] halt_cnt;
  logic [7:0]  pick;
  logic [4:0]  cmd;
  logic        heavy, arm, st, ld;
  assign cmd  = pwdata[4:0];
  assign st   = core_req.store_program_instruction;
  assign ld   = core_req.load_program_instruction;
  // Lock, ext, high, low sit at byte 0..3; pointer 1..3,0 maps onto them
  assign pick = 8'(fuses >> {core_req.pointer[1:0] - 2'h1, 3'h0});
  assign arm  = psel && penable && pready && pwrite && !pslverr
    && paddr == spfc_pkg::CSR_ADDR && !eeprom_write_busy && !core_halt
    && cmd inside {spfc_pkg::CMD_CLEAR, spfc_pkg::CMD_FUSE,
                   spfc_pkg::CMD_WRITE, spfc_pkg::CMD_ERASE,
                   spfc_pkg::CMD_STORE};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spm_cnt <= 3'h0;
      lpm_cnt <= 3'h0;
      heavy   <= 1'h0;
    end else if (arm) begin
      spm_cnt <= 3'h4;
      lpm_cnt <= (cmd == spfc_pkg::CMD_FUSE) ? 3'h3 : 3'h0;
      heavy   <= cmd inside {spfc_pkg::CMD_ERASE, spfc_pkg::CMD_WRITE};
    end else if ((st && spm_cnt != 0) || (ld && lpm_cnt != 0)) begin
      spm_cnt <= 3'h0;
      lpm_cnt <= 3'h0;
    end else begin
      spm_cnt <= (spm_cnt != 0) ? spm_cnt - 3'h1 : spm_cnt;
      lpm_cnt <= (lpm_cnt != 0) ? lpm_cnt - 3'h1 : lpm_cnt;
    end
  end
  // Not reset by presetn: a running operation outlives it
  always_ff @(posedge pclk) begin
    halt_cnt <= core_halt ? halt_cnt + 16'h1 : 16'h0;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rsv_zero;
    pready && !pwrite && paddr == spfc_pkg::CSR_ADDR |-> prdata[31:5] == 0;
  endproperty
  a_rsv_zero: assert property (p_rsv_zero)
    else $error("upper control bits not zero");
  property p_lpm_answer; ld |=> lpm_valid; endproperty
  a_lpm_answer: assert property (p_lpm_answer)
    else $error("load got no answer");
  property p_fuse_read;
    ld && lpm_cnt != 0 && !eeprom_write_busy |=> lpm_data == $past(pick);
  endproperty
  a_fuse_read: assert property (p_fuse_read)
    else $error("armed load returned wrong fuse byte");
  property p_halt_start;
    st && spm_cnt != 0 && heavy && !eeprom_write_busy
      && !fuses.ext_fuse_byte[0] && !core_halt |=> core_halt;
  endproperty
  a_halt_start: assert property (p_halt_start)
    else $error("armed store did not halt the core");
  property p_no_arm; st && spm_cnt == 0 && !core_halt |=> !core_halt;
  endproperty
  a_no_arm: assert property (p_no_arm)
    else $error("store outside window started work");
  property p_fuse_gate;
    st && fuses.ext_fuse_byte[0] && !core_halt |=> !core_halt[*3];
  endproperty
  a_fuse_gate: assert property (p_fuse_gate)
    else $error("store ran with self program fuse off");
  property p_eeprom_gate; st && eeprom_write_busy |=> $stable(core_halt);
  endproperty
  a_eeprom_gate: assert property (p_eeprom_gate)
    else $error("store ran during eeprom write");
  property p_prog_time;
    $fell(core_halt) |-> halt_cnt >= LO && halt_cnt <= HI;
  endproperty
  a_prog_time: assert property (p_prog_time)
    else $error("programming time out of range");
  c_halt: cover property ($rose(core_halt));
  c_fuse: cover property (ld && lpm_cnt != 0);
  c_err: cover property (pready && pslverr);
endmodule // spfc_monitor

bind spfc_top spfc_monitor #(.OSC_DIV(OSC_DIV), .PROG_TICKS(PROG_TICKS))
  spfc_monitor_i (.pclk(pclk), .presetn(presetn), .paddr(paddr),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .core_req(core_req), .lpm_data(lpm_data), .lpm_valid(lpm_valid),
  .core_halt(core_halt), .eeprom_write_busy(eeprom_write_busy),
  .fuses(fuses));

/* bench/spfc_core_model.sv */
`timescale 1ns/1ps
module spfc_core_model (
  // Clock and answer
  input  wire logic                pclk,
  input  wire logic                lpm_valid,
  input  wire logic [7:0]          lpm_data,
  // Strobes
  output spfc_pkg::spfc_core_req_t core_req
);
  initial core_req = '0;
  // Idle cycles carry inverted fields so stale values never match
  task automatic issue(input logic st, input logic ld,
                       input logic [15:0] p, input logic [15:0] d,
                       output logic [8:0] ans);
    core_req <= {st, ld, p, d};
    @(posedge pclk);
    core_req <= {2'h0, ~p, ~d};
    @(negedge pclk);
    ans = {lpm_valid, lpm_data};
    @(posedge pclk);
  endtask
endmodule // spfc_core_model

/* bench/spfc_top_tb.sv */
`timescale 1ns/1ps
module spfc_top_tb;
  logic                     pclk, presetn, por_n, psel, penable, pwrite;
  logic                     pready, pslverr, lpm_valid, core_halt, er;
  logic                     eeprom_write_busy, eeprom_write_start;
  logic [11:0]              paddr;
  logic [31:0]              pwdata, prdata, lf, rd;
  logic [7:0]               lpm_data;
  logic [8:0]               ans;
  logic [15:0]              fl [1024];
  logic [15:0]              bm [16];
  spfc_pkg::spfc_core_req_t core_req;
  spfc_pkg::spfc_fuse_t     fuses;
  int                       miscompares, num_checks;
  spfc_top #(.PROG_TICKS(4)) spfc_top_i (
    .pclk(pclk), .presetn(presetn), .por_n(por_n), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .core_req(core_req), .lpm_data(lpm_data), .lpm_valid(lpm_valid),
    .core_halt(core_halt), .eeprom_write_busy(eeprom_write_busy),
    .eeprom_write_start(eeprom_write_start), .fuses(fuses));
  spfc_core_model spfc_core_model_i (.pclk(pclk), .lpm_valid(lpm_valid),
    .lpm_data(lpm_data), .core_req(core_req));
  initial begin
    pclk = 1'h0;
    forever #12.5 pclk = ~pclk;
  end
  function automatic logic [31:0] nxt(input logic [31:0] l);
    return {l[30:0], l[31] ^ l[21] ^ l[1] ^ l[0]};
  endfunction
  function automatic logic [8:0] eb(input logic [15:0] p);
    return {1'h1, p[0] ? fl[p[10:1]][15:8] : fl[p[10:1]][7:0]};
  endfunction
  function automatic logic [8:0] fb(input int s);
    logic [7:0] t [4];
    t = '{fuses.low_fuse_byte, fuses.lock_byte, fuses.ext_fuse_byte,
          fuses.high_fuse_byte};
    return {1'h1, t[s]};
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(negedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    rd = prdata;
    er = pslverr;
    @(posedge pclk);
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic cmd(input logic [4:0] c);
    apb(1'h1, spfc_pkg::CSR_ADDR, 32'(c));
  endtask
  task automatic sp(input logic st, input logic ld, input logic [15:0] p);
    lf = nxt(lf);
    spfc_core_model_i.issue(st, ld, p, lf[15:0], ans);
  endtask
  task automatic rd_page(input int pg);
    for (int b = 0; b < 32; b++) begin
      sp(1'h0, 1'h1, 16'(pg * 32 + b));
      chk(32'(ans), 32'(eb(16'(pg * 32 + b))));
    end
  endtask
  task automatic wait_op(input logic rst);
    int n;
    n = 0;
    while (core_halt !== 1'h1 && n < 8) begin
      @(posedge pclk);
      n++;
    end
    chk(32'(core_halt), 32'h1);
    if (rst) begin
      presetn <= 1'h0;
      @(posedge pclk);
      presetn <= 1'h1;
      chk(32'(core_halt), 32'h1);
    end
    n = 0;
    while (core_halt === 1'h1 && n < 400) begin
      @(posedge pclk);
      n++;
    end
    chk(32'(n < 400), 32'h1);
    apb(1'h0, spfc_pkg::CSR_ADDR, 32'h0);
    chk(rd, 32'h0);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    stop_test();
  end
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {psel, penable, pwrite, eeprom_write_busy, eeprom_write_start} = '0;
    {paddr, pwdata, presetn, por_n} = '0;
    lf = 32'h00013C01;
    fuses = {lf[31:9], 1'h0, lf[7:0]};
    foreach (bm[i]) bm[i] = 16'hFFFF;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    por_n <= 1'h1;
    apb(1'h0, spfc_pkg::CSR_ADDR, 32'h0);
    chk(rd, 32'(spfc_pkg::CSR_RESET));
    apb(1'h1, spfc_pkg::CSR_ADDR, 32'hFFFFFFFF);
    apb(1'h0, spfc_pkg::CSR_ADDR, 32'h0);
    chk(rd, 32'h0);
    apb(1'h0, 12'h008, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    $display("register test done");
    for (int pg = 1; pg < 3; pg++) begin
      cmd(spfc_pkg::CMD_ERASE);
      sp(1'h1, 1'h0, 16'(pg * 32 + 7));
      wait_op(pg == 2);
      for (int w = 0; w < 16; w++) fl[pg * 16 + w] = 16'hFFFF;
      rd_page(pg);
    end
    $display("erase test done");
    for (int w = 0; w < 16; w++) begin
      cmd(spfc_pkg::CMD_STORE);
      sp(1'h1, 1'h0, 16'(32 + w * 2 + w % 2));
      bm[w] = lf[15:0];
    end
    cmd(spfc_pkg::CMD_WRITE);
    sp(1'h1, 1'h0, 16'h0020);
    wait_op(1'h0);
    for (int w = 0; w < 16; w++) fl[16 + w] &= bm[w];
    foreach (bm[i]) bm[i] = 16'hFFFF;
    rd_page(1);
    $display("page write test done");
    for (int k = 0; k < 3; k++) begin
      cmd(spfc_pkg::CMD_STORE);
      sp(1'h1, 1'h0, 16'(64 + k * 2));
      if (k == 0) cmd(spfc_pkg::CMD_CLEAR);
      @(posedge pclk);
      eeprom_write_start <= (k == 1);
      presetn <= (k != 2);
      @(posedge pclk);
      eeprom_write_start <= 1'h0;
      presetn <= 1'h1;
      cmd(spfc_pkg::CMD_WRITE);
      sp(1'h1, 1'h0, 16'h0040);
      wait_op(1'h0);
    end
    rd_page(2);
    $display("buffer discard test done");
    for (int s = 0; s < 5; s++) begin
      @(posedge pclk);
      lf = nxt(lf);
      fuses <= {lf[31:9], 1'h0, lf[7:0]};
      cmd(spfc_pkg::CMD_FUSE);
      if (s == 4) repeat (3) @(posedge pclk);
      sp(1'h0, 1'h1, 16'(s == 4 ? 32 : s));
      chk(32'(ans), 32'(s == 4 ? eb(16'h0020) : fb(s)));
    end
    $display("fuse read test done");
    for (int k = 0; k < 4; k++) begin
      @(posedge pclk);
      fuses.ext_fuse_byte[0] <= (k == 2);
      eeprom_write_busy <= (k == 3);
      if (k > 0) cmd(spfc_pkg::CMD_ERASE);
      if (k == 1) repeat (4) @(posedge pclk);
      sp(1'h1, 1'h0, 16'h0020);
      repeat (3) begin
        @(posedge pclk);
        chk(32'(core_halt), 32'h0);
      end
    end
    fuses.ext_fuse_byte[0] <= 1'h0;
    eeprom_write_busy <= 1'h0;
    rd_page(1);
    $display("refusal test done");
    stop_test();
  end
endmodule // spfc_top_tb
